// ### rtl/dso_pkg.sv
// package: codes, register map, timing constants and carriers for the drive status flags
package dso_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned LIMIT_MIN_MS = 100;
    localparam int unsigned LIMIT_DLY_MS = 20;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned LIMIT_MIN_CYCLES = LIMIT_MIN_MS * MS_CYCLES;
    localparam int unsigned LIMIT_DLY_CYCLES = LIMIT_DLY_MS * MS_CYCLES;

    localparam int unsigned TEMP_W = 12;
    localparam logic [TEMP_W-1:0] WARN_ON_MARGIN = 12'h005;
    localparam logic [TEMP_W-1:0] WARN_OFF_MARGIN = 12'h008;

    // assignment codes
    localparam logic [7:0] CODE_RUN = 8'h00;
    localparam logic [7:0] CODE_DC_LOW = 8'h03;
    localparam logic [7:0] CODE_TORQUE_POL = 8'h04;
    localparam logic [7:0] CODE_LIMIT = 8'h05;
    localparam logic [7:0] CODE_PANEL = 8'h08;
    localparam logic [7:0] CODE_READY = 8'h0a;
    localparam logic [7:0] CODE_CONTACTOR = 8'h0f;
    localparam logic [7:0] CODE_LIMIT_DLY = 8'h16;
    localparam logic [7:0] CODE_HOST_DO = 8'h1b;
    localparam logic [7:0] CODE_HEATSINK = 8'h1c;
    localparam logic [7:0] CODE_LOCK_DONE = 8'h1d;
    localparam logic [7:0] CODE_WEAR = 8'h1e;
    localparam logic [7:0] CODE_OUTPUT_ON = 8'h23;
    localparam logic [7:0] CODE_LOOP_REG = 8'h2b;

    // register map (word addresses on a 32-bit avalon slave)
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_TERM_BASE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_HOST_DO = 4'h8;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 4'h9;
    localparam logic [ADDR_W-1:0] REG_TERMS = 4'ha;
    localparam int unsigned TERM_CODE_LSB = 0;
    localparam int unsigned TERM_POL_BIT = 8;
    localparam logic [7:0] TERM_CODE_RESET = 8'hff;

    typedef struct packed {
        logic running;
        logic dc_braking;
        logic pre_exciting;
        logic zero_speed_ctrl;
        logic dew_prevent;
        logic vector_ctrl;
        logic servo_lock;
        logic above_start_freq;
        logic below_stop_freq;
    } run_state_t;

    typedef struct packed {
        logic torque_limit;
        logic sw_current_limit;
        logic hw_oc_limit;
        logic hw_oc_enable;
        logic anti_regen_decel;
    } limit_src_t;

    typedef struct packed {
        logic dc_below_level;
        logic dc_above_level;
        logic lv_trip;
        logic torque_braking;
        logic panel_selected;
        logic hw_prep_done;
        logic protect_active;
        logic forward_cmd;
        logic stop_cmd;
        logic coast_cmd;
        logic alarm;
        logic motor_stopped;
        logic fan_locked;
        logic sync_running;
        logic in_sync_angle;
        logic part_life_expired;
        logic loop_cancel_in;
        logic run_cmd;
    } drive_cond_t;

    typedef struct packed {
        logic loop_reg_active_flag;
        logic wear_flag;
        logic lock_angle_done_flag;
        logic heatsink_warn_flag;
        logic host_do_flag;
        logic contactor_ctrl_flag;
        logic ready_flag;
        logic panel_source_flag;
        logic limit_delayed_flag;
        logic limit_active_flag;
        logic torque_pol_flag;
        logic dc_bus_low_flag;
        logic output_on_flag;
        logic running_flag;
    } flags_t;

endpackage

// ### rtl/limit_stretch.sv
// stretcher and persistence timer for the output-limiting flags
`timescale 1ns/1ps
module limit_stretch #(
    parameter int unsigned MIN_CYCLES = dso_pkg::LIMIT_MIN_CYCLES,
    parameter int unsigned DLY_CYCLES = dso_pkg::LIMIT_DLY_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic limit_in,
    output logic stretched,
    output logic delayed
);
    import dso_pkg::*;

    logic [20:0] hold_q;
    logic [20:0] persist_q;

    // keep the flag up while limiting and for the minimum width after
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            hold_q <= '0;
        else if (limit_in)
            hold_q <= 21'(MIN_CYCLES - 1);
        else if (hold_q != '0)
            hold_q <= hold_q - 21'd1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            stretched <= 1'b0;
        else
            stretched <= limit_in || (hold_q != '0);
    end

    // any gap in limiting restarts the count
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            persist_q <= '0;
        else if (!limit_in)
            persist_q <= '0;
        else if (persist_q != 21'(DLY_CYCLES))
            persist_q <= persist_q + 21'd1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            delayed <= 1'b0;
        else
            delayed <= limit_in && (persist_q >= 21'(DLY_CYCLES - 1));
    end

endmodule

// ### rtl/drive_status_output_flags.sv
// drive status flag generator with programmable output terminals
// Summary of operation
// - running flag on while running, off in dc braking or dew prevention.
// - output-on flag stays on in braking, pre-excite, zero speed, dew prevention.
// - under v/f both run flags set above start, clear below stop frequency.
// - under vector control zero speed or servo lock forces both run flags on.
// - negative polarity inverts a terminal so a run flag shows stopped.
// - dc bus low flag follows link voltage against the undervoltage level.
// - dc bus low flag also on during an undervoltage trip stop.
// - run commands are ignored while dc bus low flag is on; the loop regulation flag still follows the raw run_cmd.
// - torque polarity flag low for driving, high for braking torque.
// - limit flag on while limiting, each pulse at least 100 ms.
// - delayed limit flag on only after 20 ms continuous limiting.
// - limiting sources: torque, software current, enabled hardware oc, anti-regen.
// - panel source flag on when the keypad is the run source.
// - ready flag on after preparation done and no protection active.
// - contactor flag set on forward command, cleared once stopped after stop.
// - contactor flag drops at once on coast command or alarm.
// - host output follows only the host-written value.
// - heat-sink warning on above trip minus 5, off at trip minus 8.
// - fan lock sets both heat-sink warning and wear flags.
// - lock angle done flag on in synchronous run inside the angle.
// - wear flag on when a capacitor or fan reaches end of life.
// - loop regulation flag on with loop cancel off and run command on.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module drive_status_output_flags #(
    parameter int unsigned NUM_TERMS = 8,
    parameter int unsigned MIN_CYCLES = dso_pkg::LIMIT_MIN_CYCLES,
    parameter int unsigned DLY_CYCLES = dso_pkg::LIMIT_DLY_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [dso_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire dso_pkg::run_state_t run_state,
    input wire dso_pkg::limit_src_t limit_src,
    input wire dso_pkg::drive_cond_t drive_cond,
    input wire logic [dso_pkg::TEMP_W-1:0] heatsink_temp,
    input wire logic [dso_pkg::TEMP_W-1:0] trip_temp,
    output logic run_cmd_accepted,
    output dso_pkg::flags_t flags,
    output logic [NUM_TERMS-1:0] term_out
);
    import dso_pkg::*;

    logic [7:0] term_code_q [NUM_TERMS];
    logic [NUM_TERMS-1:0] term_pol_q;
    logic host_do_q;
    logic ack_q;
    logic limit_any;
    logic limit_stretched;
    logic limit_delayed;
    logic warn_q;
    logic contactor_q;
    logic run_v;
    logic [TEMP_W-1:0] on_level;
    logic [TEMP_W-1:0] off_level;

    // one wait cycle per access keeps read data registered
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end

    generate
        for (genvar i = 0; i < NUM_TERMS; i++)
        begin : g_term_reg
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    term_code_q[i] <= TERM_CODE_RESET;
                    term_pol_q[i] <= 1'b0;
                end
                else if (avs_write && !ack_q && avs_address == REG_TERM_BASE + ADDR_W'(i))
                begin
                    if (avs_byteenable[0])
                        term_code_q[i] <= avs_writedata[TERM_CODE_LSB +: 8];
                    if (avs_byteenable[1])
                        term_pol_q[i] <= avs_writedata[TERM_POL_BIT];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            host_do_q <= 1'b0;
        else if (avs_write && !ack_q && avs_address == REG_HOST_DO && avs_byteenable[0])
            host_do_q <= avs_writedata[0];
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            avs_readdata <= '0;
        else if (avs_read && !ack_q)
        begin
            if (avs_address < ADDR_W'(NUM_TERMS))
                avs_readdata <= {23'h000000, term_pol_q[avs_address[2:0]],
                                 term_code_q[avs_address[2:0]]};
            else if (avs_address == REG_HOST_DO)
                avs_readdata <= {31'h00000000, host_do_q};
            else if (avs_address == REG_FLAGS)
                avs_readdata <= {18'h00000, flags};
            else if (avs_address == REG_TERMS)
                avs_readdata <= 32'(term_out);
            else
                avs_readdata <= '0;
        end
    end

    assign limit_any = limit_src.torque_limit || limit_src.sw_current_limit
                     || (limit_src.hw_oc_limit && limit_src.hw_oc_enable)
                     || limit_src.anti_regen_decel;

    limit_stretch #(
        .MIN_CYCLES(MIN_CYCLES),
        .DLY_CYCLES(DLY_CYCLES)
    ) u_limit (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .limit_in(limit_any),
        .stretched(limit_stretched),
        .delayed(limit_delayed)
    );

    // v/f run state with start/stop frequency hysteresis
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            run_v <= 1'b0;
        else if (!run_state.running || run_state.below_stop_freq)
            run_v <= 1'b0;
        else if (run_state.above_start_freq)
            run_v <= 1'b1;
    end

    assign on_level = trip_temp - WARN_ON_MARGIN;
    assign off_level = trip_temp - WARN_OFF_MARGIN;

    // hysteresis avoids chatter near the trip margin
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            warn_q <= 1'b0;
        else if (heatsink_temp > on_level)
            warn_q <= 1'b1;
        else if (heatsink_temp <= off_level)
            warn_q <= 1'b0;
    end

    // alarm and coast beat a simultaneous forward command
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            contactor_q <= 1'b0;
        else if (drive_cond.coast_cmd || drive_cond.alarm)
            contactor_q <= 1'b0;
        else if (drive_cond.forward_cmd && !flags.dc_bus_low_flag)
            contactor_q <= 1'b1;
        else if (drive_cond.stop_cmd && drive_cond.motor_stopped)
            contactor_q <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            run_cmd_accepted <= 1'b0;
        else
            run_cmd_accepted <= drive_cond.run_cmd && !flags.dc_bus_low_flag;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            flags <= '0;
        else
        begin
            flags.running_flag <= (run_state.vector_ctrl
                                   && (run_state.zero_speed_ctrl || run_state.servo_lock))
                                  || (run_v && !run_state.dc_braking
                                      && !run_state.dew_prevent);
            flags.output_on_flag <= (run_state.vector_ctrl
                                     && (run_state.zero_speed_ctrl || run_state.servo_lock))
                                    || run_v || run_state.dc_braking
                                    || run_state.pre_exciting || run_state.zero_speed_ctrl
                                    || run_state.dew_prevent;
            if (drive_cond.lv_trip || drive_cond.dc_below_level)
                flags.dc_bus_low_flag <= 1'b1;
            else if (drive_cond.dc_above_level)
                flags.dc_bus_low_flag <= 1'b0;
            flags.torque_pol_flag <= drive_cond.torque_braking;
            flags.limit_active_flag <= limit_stretched;
            flags.limit_delayed_flag <= limit_delayed;
            flags.panel_source_flag <= drive_cond.panel_selected;
            flags.ready_flag <= drive_cond.hw_prep_done && !drive_cond.protect_active;
            // coast or alarm drops the flag in the same edge as the latch, not one later
            flags.contactor_ctrl_flag <= contactor_q && !drive_cond.coast_cmd
                                         && !drive_cond.alarm;
            flags.host_do_flag <= host_do_q;
            flags.heatsink_warn_flag <= warn_q || drive_cond.fan_locked;
            flags.lock_angle_done_flag <= drive_cond.sync_running
                                          && drive_cond.in_sync_angle;
            flags.wear_flag <= drive_cond.part_life_expired || drive_cond.fan_locked;
            flags.loop_reg_active_flag <= !drive_cond.loop_cancel_in
                                          && drive_cond.run_cmd;
        end
    end

    generate
        for (genvar t = 0; t < NUM_TERMS; t++)
        begin : g_term_out
            logic sel;
            always_comb
            begin
                unique case (term_code_q[t])
                    CODE_RUN: sel = flags.running_flag;
                    CODE_OUTPUT_ON: sel = flags.output_on_flag;
                    CODE_DC_LOW: sel = flags.dc_bus_low_flag;
                    CODE_TORQUE_POL: sel = flags.torque_pol_flag;
                    CODE_LIMIT: sel = flags.limit_active_flag;
                    CODE_LIMIT_DLY: sel = flags.limit_delayed_flag;
                    CODE_PANEL: sel = flags.panel_source_flag;
                    CODE_READY: sel = flags.ready_flag;
                    CODE_CONTACTOR: sel = flags.contactor_ctrl_flag;
                    CODE_HOST_DO: sel = flags.host_do_flag;
                    CODE_HEATSINK: sel = flags.heatsink_warn_flag;
                    CODE_LOCK_DONE: sel = flags.lock_angle_done_flag;
                    CODE_WEAR: sel = flags.wear_flag;
                    CODE_LOOP_REG: sel = flags.loop_reg_active_flag;
                    default: sel = 1'b0;
                endcase
            end
            // polarity applies to any code; unassigned codes show low, or high when inverted
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                    term_out[t] <= 1'b0;
                else
                    term_out[t] <= sel ^ term_pol_q[t];
            end
        end
    endgenerate

endmodule

// ### verification/dso_properties.sv
// checker: port-level properties of the drive status flag generator
`timescale 1ns/1ps
module dso_properties #(
    parameter int unsigned NUM_TERMS = 8,
    parameter int unsigned MIN_CYCLES = 50,
    parameter int unsigned DLY_CYCLES = 10
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [dso_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire dso_pkg::run_state_t run_state,
    input wire dso_pkg::limit_src_t limit_src,
    input wire dso_pkg::drive_cond_t drive_cond,
    input wire logic [dso_pkg::TEMP_W-1:0] heatsink_temp,
    input wire logic [dso_pkg::TEMP_W-1:0] trip_temp,
    input wire logic run_cmd_accepted,
    input wire dso_pkg::flags_t flags,
    input wire logic [NUM_TERMS-1:0] term_out
);
    import dso_pkg::*;
    logic src_any;
    logic [31:0] hi_cnt_q;
    logic [31:0] run_q;
    // hardware overcurrent only counts while its enable is set
    assign src_any = limit_src.torque_limit | limit_src.sw_current_limit
        | (limit_src.hw_oc_limit & limit_src.hw_oc_enable) | limit_src.anti_regen_decel;
    // counters are wide so a long limiting spell cannot wrap and fake a short pulse
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            hi_cnt_q <= '0;
        else
            hi_cnt_q <= flags.limit_active_flag ? hi_cnt_q + 32'h1 : '0;
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            run_q <= '0;
        else
            run_q <= src_any ? run_q + 32'h1 : '0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_limiting;
        src_any ##1 src_any;
    endsequence
    a_bus_answer: assert property (s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    a_run_braking: assert property ((run_state.dc_braking || run_state.dew_prevent)
        && !run_state.vector_ctrl |=> !flags.running_flag)
        else $error("running flag on during braking or dew prevention");
    a_output_on_hold: assert property ((run_state.dc_braking || run_state.pre_exciting
        || run_state.zero_speed_ctrl || run_state.dew_prevent) |=> flags.output_on_flag)
        else $error("output-on flag dropped");
    a_vector_force: assert property (run_state.vector_ctrl && (run_state.zero_speed_ctrl
        || run_state.servo_lock) |=> flags.running_flag && flags.output_on_flag)
        else $error("run flags not forced under vector control");
    a_dc_low_set: assert property (drive_cond.dc_below_level || drive_cond.lv_trip
        |=> flags.dc_bus_low_flag)
        else $error("dc bus low flag not set");
    a_run_gated: assert property (flags.dc_bus_low_flag && !drive_cond.dc_above_level
        |=> !run_cmd_accepted)
        else $error("run command accepted on low dc bus");
    a_torque_pol: assert property ($rose(drive_cond.torque_braking) |=> flags.torque_pol_flag)
        else $error("torque polarity flag not high for braking");
    a_limit_on: assert property (s_limiting |=> flags.limit_active_flag)
        else $error("limit flag not on while limiting");
    a_limit_width: assert property ($fell(flags.limit_active_flag) |-> hi_cnt_q >= MIN_CYCLES)
        else $error("limit flag pulse too short");
    a_limit_delay: assert property ($rose(flags.limit_delayed_flag)
        |-> $past(run_q, 2) + 32'h2 >= DLY_CYCLES)
        else $error("delayed limit flag rose too early");
    a_contactor_drop: assert property (drive_cond.coast_cmd || drive_cond.alarm
        |=> !flags.contactor_ctrl_flag)
        else $error("contactor flag held after coast or alarm");
    a_fan_lock: assert property (drive_cond.fan_locked
        |=> flags.heatsink_warn_flag && flags.wear_flag)
        else $error("fan lock not shown on warning and wear flags");
endmodule

bind drive_status_output_flags dso_properties #(.NUM_TERMS(NUM_TERMS),
    .MIN_CYCLES(MIN_CYCLES), .DLY_CYCLES(DLY_CYCLES)) i_props (.sys_clk(sys_clk),
    .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_state(run_state),
    .limit_src(limit_src), .drive_cond(drive_cond), .heatsink_temp(heatsink_temp),
    .trip_temp(trip_temp), .run_cmd_accepted(run_cmd_accepted), .flags(flags),
    .term_out(term_out));

// ### verification/terminal_reader.sv
// partner: external equipment latching the drive's output terminals
`timescale 1ns/1ps
module terminal_reader #(
    parameter int unsigned NUM_TERMS = 8
) (
    input wire logic sys_clk,
    input wire logic [NUM_TERMS-1:0] term_in,
    output logic [NUM_TERMS-1:0] seen
);
    // plain level inputs read one clock late, as an input relay stage would
    always_ff @(posedge sys_clk)
    begin
        seen <= term_in;
    end
endmodule

// ### verification/drive_status_output_flags_tb_top.sv
// testbench: table-driven and hand checks of the drive status flag generator
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module drive_status_output_flags_tb_top;
    import dso_pkg::*;
    localparam int unsigned MIN_C = 50;
    localparam int unsigned DLY_C = 10;
    localparam logic [7:0] POL = 8'h02;
    typedef struct packed {
        run_state_t rs;
        drive_cond_t dc;
        logic [TEMP_W-1:0] t;
        flags_t f;
    } row_t;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    run_state_t run_state = '0;
    limit_src_t limit_src = '0;
    drive_cond_t drive_cond = '0;
    logic [TEMP_W-1:0] heatsink_temp = '0;
    logic [TEMP_W-1:0] trip_temp = 12'h064;
    logic run_cmd_accepted;
    flags_t flags;
    logic [7:0] term_out;
    logic [7:0] seen;
    logic [31:0] rd;
    int bad_count = 0;
    int comparisons = 0;
    logic [7:0] codes [8] = '{CODE_RUN, CODE_RUN, CODE_DC_LOW, CODE_LIMIT, CODE_LIMIT_DLY,
        CODE_HOST_DO, CODE_HEATSINK, CODE_CONTACTOR};
    limit_src_t srcs [5] = '{5'h10, 5'h08, 5'h06, 5'h01, 5'h04};
    // rows run in order: latched flags (dc low, contactor, heat) depend on the row before
    row_t rows [] = '{{9'h001,18'h01000,12'h032,14'h0280}, {9'h102,18'h01001,12'h032,14'h2283},
        {9'h182,18'h01000,12'h032,14'h0282}, {9'h028,18'h01000,12'h032,14'h0283},
        {9'h00c,18'h01000,12'h032,14'h0283}, {9'h001,18'h01000,12'h032,14'h0280},
        {9'h011,18'h01000,12'h032,14'h0282}, {9'h041,18'h01000,12'h032,14'h0282},
        {9'h001,18'h21000,12'h032,14'h0284}, {9'h001,18'h01000,12'h032,14'h0284},
        {9'h001,18'h11000,12'h032,14'h0280}, {9'h001,18'h09000,12'h032,14'h0284},
        {9'h001,18'h11000,12'h032,14'h0280}, {9'h001,18'h05000,12'h032,14'h0288},
        {9'h001,18'h03000,12'h032,14'h02c0}, {9'h001,18'h01800,12'h032,14'h0200},
        {9'h001,18'h01400,12'h032,14'h0380}, {9'h001,18'h01200,12'h032,14'h0380},
        {9'h001,18'h01240,12'h032,14'h0280}, {9'h001,18'h01400,12'h032,14'h0380},
        {9'h001,18'h01100,12'h032,14'h0280}, {9'h001,18'h01400,12'h032,14'h0380},
        {9'h001,18'h01080,12'h032,14'h0280}, {9'h001,18'h01020,12'h032,14'h1680},
        {9'h001,18'h01004,12'h032,14'h1280}, {9'h001,18'h01018,12'h032,14'h0a80},
        {9'h001,18'h01003,12'h032,14'h0280}, {9'h001,18'h01000,12'h060,14'h0680},
        {9'h001,18'h01000,12'h05d,14'h0680}, {9'h001,18'h01000,12'h05c,14'h0280},
        {9'h001,18'h01000,12'h05f,14'h0280}};

    always #50 sys_clk = ~sys_clk;

    drive_status_output_flags #(.NUM_TERMS(8), .MIN_CYCLES(MIN_C), .DLY_CYCLES(DLY_C)) i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_state(run_state),
        .limit_src(limit_src), .drive_cond(drive_cond), .heatsink_temp(heatsink_temp),
        .trip_temp(trip_temp), .run_cmd_accepted(run_cmd_accepted), .flags(flags),
        .term_out(term_out));
    terminal_reader #(.NUM_TERMS(8)) i_reader (.sys_clk(sys_clk), .term_in(term_out),
        .seen(seen));

    function automatic logic [7:0] exp_terms(flags_t f);
        logic [7:0] v;
        v = '0;
        for (int t = 0; t < 8; t++)
        begin
            case (codes[t])
                CODE_RUN: v[t] = f.running_flag;
                CODE_DC_LOW: v[t] = f.dc_bus_low_flag;
                CODE_LIMIT: v[t] = f.limit_active_flag;
                CODE_LIMIT_DLY: v[t] = f.limit_delayed_flag;
                CODE_HOST_DO: v[t] = f.host_do_flag;
                CODE_HEATSINK: v[t] = f.heatsink_warn_flag;
                default: v[t] = f.contactor_ctrl_flag;
            endcase
            v[t] = v[t] ^ POL[t];
        end
        return v;
    endfunction

    task end_of_test();
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one edge passes first so a back-to-back call never re-raises in the drop step
    task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            bad_count++;
            end_of_test();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    initial
    begin
        step(12);
        `CHK(term_out, 8'h00)
        `CHK(avs_waitrequest, 1'b1)
        reset_n <= 1'b1;
        for (int t = 0; t < 8; t++)
            bus(1'b1, REG_TERM_BASE + 4'(t), {23'h0, POL[t], codes[t]});
        bus(1'b1, REG_HOST_DO, 32'h1);
        bus(1'b0, REG_TERM_BASE + 4'h1, 32'h0);
        `CHK(rd, 32'h100)
        bus(1'b0, 4'hb, 32'h0);
        `CHK(rd, 32'h0)
        foreach (rows[i])
        begin
            run_state <= rows[i].rs;
            drive_cond <= rows[i].dc;
            heatsink_temp <= rows[i].t;
            // input, flag, terminal and reader stages each take an edge
            step(5);
            `CHK(flags, rows[i].f)
            `CHK(seen, exp_terms(rows[i].f))
        end
        bus(1'b0, REG_FLAGS, 32'h0);
        `CHK(rd[13:0], rows[rows.size()-1].f)
        drive_cond <= 18'h21001;
        step(4);
        `CHK(run_cmd_accepted, 1'b0)
        drive_cond <= 18'h11001;
        step(4);
        `CHK(run_cmd_accepted, 1'b1)
        bus(1'b1, REG_HOST_DO, 32'h0);
        step(2);
        `CHK(flags.host_do_flag, 1'b0)
        for (int s = 0; s < 5; s++)
        begin
            limit_src <= srcs[s];
            step(DLY_C + 4);
            `CHK(flags.limit_delayed_flag, s != 4)
            `CHK(flags.limit_active_flag, s != 4)
            limit_src <= '0;
            step(MIN_C - 8);
            `CHK(flags.limit_active_flag, s != 4)
            step(20);
            `CHK(flags.limit_active_flag, 1'b0)
        end
        limit_src <= 5'h10;
        step(DLY_C - 4);
        limit_src <= '0;
        step(4);
        `CHK(flags.limit_delayed_flag, 1'b0)
        `CHK(flags.limit_active_flag, 1'b1)
        end_of_test();
    end

    initial
    begin
        #2_000_000;
        bad_count++;
        end_of_test();
    end
endmodule
